// ==== design/gfx_datapath_regs.vh ====
`ifndef GFX_DATAPATH_REGS_VH
`define GFX_DATAPATH_REGS_VH

// ----------------------------------------
// io ports and register indices
// ----------------------------------------
`define GFX_PORT_INDEX 16'h03ce
`define GFX_PORT_DATA 16'h03cf
`define GFX_IDX_SET_RESET 4'h0
`define GFX_IDX_SR_ENABLE 4'h1
`define GFX_IDX_CMP_COLOR 4'h2
`define GFX_IDX_ROTATE 4'h3
`define GFX_IDX_READ_PLANE 4'h4
`define GFX_IDX_MODE 4'h5
`define GFX_IDX_MISC 4'h6
`define GFX_IDX_CMP_INCLUDE 4'h7
`define GFX_IDX_BIT_MASK 4'h8

// ----------------------------------------
// field positions
// ----------------------------------------
`define ROT_FUNC_HI 4
`define ROT_FUNC_LO 3
`define ROT_CNT_HI 2
`define ROT_CNT_LO 0
`define MODE_256 6
`define MODE_SHIFT_FMT 5
`define MODE_ODD_EVEN 4
`define MODE_READ_CMP 3
`define MODE_WR_HI 1
`define MODE_WR_LO 0
`define MISC_WIN_HI 3
`define MISC_WIN_LO 2
`define MISC_ODD_EVEN 1
`define MISC_GFX 0

// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define FUNC_PASS 2'h0
`define FUNC_AND 2'h1
`define FUNC_OR 2'h2
`define FUNC_XOR 2'h3
`define WMODE_0 2'h0
`define WMODE_1 2'h1
`define WMODE_2 2'h2
`define WMODE_3 2'h3
`define WIN_A0_BF 2'h0
`define WIN_A0_AF 2'h1
`define WIN_B0_B7 2'h2
`define WIN_B8_BF 2'h3
`define SEG_A 5'h14
`define SEG_B 5'h16
`define SEG_B8 5'h17
`define REG_RESET 8'h00

`endif

// ==== design/gfx_plane_writer.v ====
`timescale 1ns/1ps
`include "gfx_datapath_regs.vh"

module gfx_plane_writer (
	input wire [1:0] wmode_i,
	input wire [1:0] func_i,
	input wire [7:0] rot_data_i,
	input wire sr_bit_i,
	input wire sr_en_i,
	input wire cpu_bit_i,
	input wire [7:0] bit_mask_i,
	input wire [7:0] latch_i,
	output reg [7:0] wdata_o
);
	reg [7:0] src;
	reg [7:0] alu;
	reg [7:0] msk;

	always @* begin
		src = rot_data_i;
		msk = bit_mask_i;
		case (wmode_i)
			`WMODE_0: src = sr_en_i ? {8{sr_bit_i}} : rot_data_i;
			`WMODE_2: src = {8{cpu_bit_i}};
			`WMODE_3: begin
				src = {8{sr_bit_i}};
				msk = rot_data_i & bit_mask_i;
			end
			default: src = rot_data_i;
		endcase
		case (func_i)
			`FUNC_AND: alu = src & latch_i;
			`FUNC_OR: alu = src | latch_i;
			`FUNC_XOR: alu = src ^ latch_i;
			default: alu = src;
		endcase
		// masked positions keep the latched byte
		if (wmode_i == `WMODE_1)
			wdata_o = latch_i;
		else
			wdata_o = (alu & msk) | (latch_i & ~msk);
	end
endmodule

// ==== design/gfx_shift_loader.v ====
`timescale 1ns/1ps
`include "gfx_datapath_regs.vh"

module gfx_shift_loader (
	input wire mclk_i,
	input wire reset_n_i,
	input wire load_i,
	input wire dot_en_i,
	input wire [31:0] data_i,
	input wire mode256_i,
	input wire shift_fmt_i,
	input wire [1:0] attr_msb_i,
	output reg [7:0] pixel_o
);
	reg [31:0] sh_q;
	reg [1:0] byte_q;
	wire [7:0] m0 = data_i[7:0];
	wire [7:0] m1 = data_i[15:8];
	wire [7:0] m2 = data_i[23:16];
	wire [7:0] m3 = data_i[31:24];
	wire [31:0] fmt_cga = {m3[7], m3[5], m3[3], m3[1], m2[7], m2[5], m2[3], m2[1],
		m3[6], m3[4], m3[2], m3[0], m2[6], m2[4], m2[2], m2[0],
		m1[7], m1[5], m1[3], m1[1], m0[7], m0[5], m0[3], m0[1],
		m1[6], m1[4], m1[2], m1[0], m0[6], m0[4], m0[2], m0[0]};
	wire [3:0] plane_bits = {sh_q[31], sh_q[23], sh_q[15], sh_q[7]};
	reg [7:0] byte_sel;

	always @* begin
		case (byte_q)
			2'h0: byte_sel = sh_q[7:0];
			2'h1: byte_sel = sh_q[15:8];
			2'h2: byte_sel = sh_q[23:16];
			default: byte_sel = sh_q[31:24];
		endcase
	end

	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sh_q <= 32'h00000000;
			byte_q <= 2'h0;
			pixel_o <= 8'h00;
		end else if (load_i) begin
			// 256-colour keeps bytes whole; otherwise the shift format bit picks interleaved or per-register layout
			sh_q <= (shift_fmt_i && !mode256_i) ? fmt_cga : data_i;
			byte_q <= 2'h0;
		end else if (dot_en_i) begin
			if (mode256_i) begin
				pixel_o <= byte_sel;
				byte_q <= byte_q + 2'h1;
			end else begin
				// msb leaves first in every register
				pixel_o <= {attr_msb_i, 2'h0, plane_bits};
				sh_q <= {sh_q[30:24], 1'b0, sh_q[22:16], 1'b0, sh_q[14:8], 1'b0,
					sh_q[6:0], 1'b0};
			end
		end
	end
endmodule

// ==== design/gfx_datapath.v ====
`timescale 1ns/1ps
`include "gfx_datapath_regs.vh"

module gfx_datapath #(
	parameter MAP_AW = 16
) (
	input wire mclk_i,
	input wire reset_n_i,
	input wire [15:0] io_addr_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire [7:0] io_wdata_i,
	output reg [7:0] io_rdata_o,
	output reg io_rvalid_o,
	input wire [19:0] mem_addr_i,
	input wire mem_wr_i,
	input wire mem_rd_i,
	input wire [7:0] mem_wdata_i,
	output wire mem_hit_o,
	output reg [7:0] mem_rdata_o,
	output reg mem_rvalid_o,
	input wire seq_chain_i,
	output reg [MAP_AW-1:0] map_addr_o,
	output reg [3:0] map_we_o,
	output reg map_rd_o,
	output reg [31:0] map_wdata_o,
	input wire [31:0] map_rdata_i,
	input wire map_rvalid_i,
	input wire shift_load_i,
	input wire dot_en_i,
	input wire [31:0] shift_data_i,
	input wire [1:0] attr_msb_i,
	output wire [7:0] pixel_o,
	output wire gfx_mode_o
);
	// ----------------------------------------
	// register file
	// ----------------------------------------
	reg [3:0] index_q;
	reg [3:0] set_reset_q;
	reg [3:0] sr_enable_q;
	reg [3:0] cmp_color_q;
	reg [4:0] write_rotate_function_q;
	reg [1:0] read_plane_select_q;
	reg [7:0] gfx_mode_control_q;
	reg [3:0] gfx_misc_control_q;
	reg [3:0] compare_plane_include_q;
	reg [7:0] write_bit_mask_q;
	reg [31:0] latch_q;
	reg rd_pend_q;
	reg [1:0] rd_plane_q;
	reg [7:0] reg_rd;

	wire idx_sel = (io_addr_i == `GFX_PORT_INDEX);
	wire dat_sel = (io_addr_i == `GFX_PORT_DATA);
	wire [1:0] func = write_rotate_function_q[`ROT_FUNC_HI:`ROT_FUNC_LO];
	wire [2:0] rot_cnt = write_rotate_function_q[`ROT_CNT_HI:`ROT_CNT_LO];
	wire [1:0] wmode = gfx_mode_control_q[`MODE_WR_HI:`MODE_WR_LO];
	wire read_cmp = gfx_mode_control_q[`MODE_READ_CMP];
	wire [1:0] window = gfx_misc_control_q[`MISC_WIN_HI:`MISC_WIN_LO];
	wire odd_even = gfx_misc_control_q[`MISC_ODD_EVEN] | gfx_mode_control_q[`MODE_ODD_EVEN];

	assign gfx_mode_o = gfx_misc_control_q[`MISC_GFX];

	// ----------------------------------------
	// register writes through the index port
	// ----------------------------------------
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			index_q <= 4'h0;
			set_reset_q <= 4'h0;
			sr_enable_q <= 4'h0;
			cmp_color_q <= 4'h0;
			write_rotate_function_q <= 5'h00;
			read_plane_select_q <= 2'h0;
			gfx_mode_control_q <= `REG_RESET;
			gfx_misc_control_q <= 4'h0;
			compare_plane_include_q <= 4'h0;
			write_bit_mask_q <= `REG_RESET;
		end else if (io_wr_i && idx_sel) begin
			index_q <= io_wdata_i[3:0];
		end else if (io_wr_i && dat_sel) begin
			case (index_q)
				`GFX_IDX_SET_RESET: set_reset_q <= io_wdata_i[3:0];
				`GFX_IDX_SR_ENABLE: sr_enable_q <= io_wdata_i[3:0];
				`GFX_IDX_CMP_COLOR: cmp_color_q <= io_wdata_i[3:0];
				`GFX_IDX_ROTATE: write_rotate_function_q <= io_wdata_i[4:0];
				`GFX_IDX_READ_PLANE: read_plane_select_q <= io_wdata_i[1:0];
				// bits 7 and 2 are reserved and held at zero
				`GFX_IDX_MODE: gfx_mode_control_q <= io_wdata_i & 8'h7b;
				`GFX_IDX_MISC: gfx_misc_control_q <= io_wdata_i[3:0];
				`GFX_IDX_CMP_INCLUDE: compare_plane_include_q <= io_wdata_i[3:0];
				`GFX_IDX_BIT_MASK: write_bit_mask_q <= io_wdata_i;
				default: index_q <= index_q;
			endcase
		end
	end

	// ----------------------------------------
	// register readback
	// ----------------------------------------
	always @* begin
		case (index_q)
			`GFX_IDX_SET_RESET: reg_rd = {4'h0, set_reset_q};
			`GFX_IDX_SR_ENABLE: reg_rd = {4'h0, sr_enable_q};
			`GFX_IDX_CMP_COLOR: reg_rd = {4'h0, cmp_color_q};
			`GFX_IDX_ROTATE: reg_rd = {3'h0, write_rotate_function_q};
			`GFX_IDX_READ_PLANE: reg_rd = {6'h00, read_plane_select_q};
			`GFX_IDX_MODE: reg_rd = gfx_mode_control_q;
			`GFX_IDX_MISC: reg_rd = {4'h0, gfx_misc_control_q};
			`GFX_IDX_CMP_INCLUDE: reg_rd = {4'h0, compare_plane_include_q};
			`GFX_IDX_BIT_MASK: reg_rd = write_bit_mask_q;
			default: reg_rd = 8'h00;
		endcase
	end

	// ----------------------------------------
	// io read answer
	// ----------------------------------------
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			io_rdata_o <= 8'h00;
			io_rvalid_o <= 1'b0;
		end else begin
			io_rvalid_o <= io_rd_i & (idx_sel | dat_sel);
			if (io_rd_i && idx_sel)
				io_rdata_o <= {4'h0, index_q};
			else if (io_rd_i && dat_sel)
				io_rdata_o <= reg_rd;
		end
	end

	// ----------------------------------------
	// memory window and map addressing
	// ----------------------------------------
	reg win_hit;
	reg [16:0] win_off;

	always @* begin
		win_off = mem_addr_i[16:0];
		case (window)
			`WIN_A0_BF: win_hit = ({mem_addr_i[19:17], 2'h0} == `SEG_A);
			`WIN_A0_AF: win_hit = ({mem_addr_i[19:16], 1'b0} == `SEG_A);
			`WIN_B0_B7: win_hit = (mem_addr_i[19:15] == `SEG_B);
			default: win_hit = (mem_addr_i[19:15] == `SEG_B8);
		endcase
		// smaller windows start their map offset at zero
		if (window != `WIN_A0_BF)
			win_off[16] = 1'b0;
		if (window[1])
			win_off[15] = 1'b0;
	end

	assign mem_hit_o = win_hit & (mem_rd_i | mem_wr_i);

	// ----------------------------------------
	// odd/even map steering
	// ----------------------------------------
	// odd/even: a0 picks the map pair; it is replaced by the top window bit
	wire [3:0] pair_en = win_off[0] ? 4'ha : 4'h5;
	wire [MAP_AW-1:0] oe_addr = {win_off[MAP_AW-1:1], win_off[MAP_AW]};
	wire [MAP_AW-1:0] map_addr = odd_even ? oe_addr : win_off[MAP_AW-1:0];
	wire [3:0] map_en = odd_even ? pair_en : 4'hf;

	// ----------------------------------------
	// write path
	// ----------------------------------------
	wire [15:0] rot_dbl = {mem_wdata_i, mem_wdata_i};
	wire [7:0] rot_data = rot_dbl[rot_cnt +: 8];
	wire [31:0] wr_bytes;

	// ----------------------------------------
	// per-map write data
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_plane
			gfx_plane_writer u_writer (
				.wmode_i(wmode),
				.func_i(func),
				.rot_data_i(rot_data),
				.sr_bit_i(set_reset_q[gi]),
				.sr_en_i(sr_enable_q[gi]),
				.cpu_bit_i(mem_wdata_i[gi]),
				.bit_mask_i(write_bit_mask_q),
				.latch_i(latch_q[8*gi +: 8]),
				.wdata_o(wr_bytes[8*gi +: 8])
			);
		end
	endgenerate

	// ----------------------------------------
	// map port requests
	// ----------------------------------------
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			map_addr_o <= {MAP_AW{1'b0}};
			map_we_o <= 4'h0;
			map_rd_o <= 1'b0;
			map_wdata_o <= 32'h00000000;
		end else begin
			map_we_o <= 4'h0;
			map_rd_o <= 1'b0;
			if (mem_wr_i && win_hit) begin
				map_addr_o <= map_addr;
				map_wdata_o <= wr_bytes;
				map_we_o <= map_en;
			end else if (mem_rd_i && win_hit) begin
				map_addr_o <= map_addr;
				map_rd_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// read path and latches
	// ----------------------------------------
	wire [7:0] cmp_vec [0:3];
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
			assign cmp_vec[gi] = ~(map_rdata_i[8*gi +: 8] ^ {8{cmp_color_q[gi]}})
				| {8{~compare_plane_include_q[gi]}};
		end
	endgenerate
	wire [7:0] cmp_result = cmp_vec[0] & cmp_vec[1] & cmp_vec[2] & cmp_vec[3];

	// ----------------------------------------
	// plane select for reads
	// ----------------------------------------
	reg [1:0] plane_pick;
	always @* begin
		// chained addressing: low address bits pick the plane
		if (seq_chain_i)
			plane_pick = win_off[1:0];
		else if (odd_even)
			plane_pick = {read_plane_select_q[1], win_off[0]};
		else
			plane_pick = read_plane_select_q;
	end

	// ----------------------------------------
	// read answer and latches
	// ----------------------------------------
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			latch_q <= 32'h00000000;
			rd_pend_q <= 1'b0;
			rd_plane_q <= 2'h0;
			mem_rdata_o <= 8'h00;
			mem_rvalid_o <= 1'b0;
		end else begin
			mem_rvalid_o <= 1'b0;
			if (map_rvalid_i && rd_pend_q) begin
				rd_pend_q <= 1'b0;
				latch_q <= map_rdata_i;
				mem_rvalid_o <= 1'b1;
				if (read_cmp)
					mem_rdata_o <= cmp_result;
				else
					mem_rdata_o <= map_rdata_i[8*rd_plane_q +: 8];
			end
			// a new read in the answering cycle must stay pending
			if (mem_rd_i && win_hit) begin
				rd_pend_q <= 1'b1;
				rd_plane_q <= plane_pick;
			end
		end
	end

	// ----------------------------------------
	// video shift load
	// ----------------------------------------
	gfx_shift_loader u_shift (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.load_i(shift_load_i),
		.dot_en_i(dot_en_i),
		.data_i(shift_data_i),
		.mode256_i(gfx_mode_control_q[`MODE_256]),
		.shift_fmt_i(gfx_mode_control_q[`MODE_SHIFT_FMT]),
		.attr_msb_i(attr_msb_i),
		.pixel_o(pixel_o)
	);
endmodule

// ==== sim/gfx_datapath_asserts.sv ====
`timescale 1ns/1ps
module gfx_datapath_asserts (
	input wire mclk_i,
	input wire reset_n_i,
	input wire [15:0] io_addr_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire [7:0] io_wdata_i,
	input wire io_rvalid_o,
	input wire [19:0] mem_addr_i,
	input wire mem_wr_i,
	input wire mem_rd_i,
	input wire mem_hit_o,
	input wire mem_rvalid_o,
	input wire [3:0] map_we_o,
	input wire map_rd_o,
	input wire map_rvalid_i,
	input wire shift_load_i,
	input wire dot_en_i,
	input wire [7:0] pixel_o
);
	// ----------------------------------------
	// shadow of index and window field
	// ----------------------------------------
	logic [3:0] idx_q;
	logic [1:0] win_q;
	logic hit_d;
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			idx_q <= 4'h0;
			win_q <= 2'h0;
		end else if (io_wr_i && io_addr_i == 16'h03ce) begin
			idx_q <= io_wdata_i[3:0];
		end else if (io_wr_i && io_addr_i == 16'h03cf && idx_q == 4'h6) begin
			win_q <= io_wdata_i[3:2];
		end
	end
	always @* begin
		case (win_q)
			2'h0: hit_d = mem_addr_i[19:17] == 3'h5;
			2'h1: hit_d = mem_addr_i[19:16] == 4'ha;
			2'h2: hit_d = mem_addr_i[19:15] == 5'h16;
			default: hit_d = mem_addr_i[19:15] == 5'h17;
		endcase
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);
	chk_io_rd_answer: assert property (io_rd_i && io_addr_i[15:1] == 15'h01e7 |=> io_rvalid_o)
		else $error("io read not answered");
	chk_io_rv_cause: assert property (io_rvalid_o |-> $past(io_rd_i))
		else $error("io answer without read");
	chk_win_hit: assert property (mem_hit_o == (hit_d && (mem_rd_i || mem_wr_i)))
		else $error("window decode wrong");
	chk_map_rd_issue: assert property (mem_rd_i && mem_hit_o |=> map_rd_o)
		else $error("map read not issued");
	chk_we_issue: assert property (mem_wr_i && mem_hit_o |=> map_we_o != 4'h0)
		else $error("map write not issued");
	chk_we_cause: assert property (map_we_o != 4'h0 |-> $past(mem_wr_i && mem_hit_o))
		else $error("stray map write");
	chk_rdata_return: assert property (mem_rvalid_o |-> $past(map_rvalid_i))
		else $error("read data without map data");
	chk_pixel_hold: assert property (!dot_en_i && !shift_load_i |=> $stable(pixel_o))
		else $error("pixel moved without dot");
	cov_reg_read: cover property (io_rvalid_o);
	cov_mem_read: cover property (mem_rvalid_o);
	cov_odd_write: cover property (map_we_o == 4'ha);
endmodule

// ==== sim/map_mem_model.sv ====
`timescale 1ns/1ps
module map_mem_model (
	input wire mclk_i,
	input wire [15:0] addr_i,
	input wire [3:0] we_i,
	input wire rd_i,
	input wire [31:0] wdata_i,
	input wire slow_i,
	output logic [31:0] rdata_o,
	output logic rvalid_o
);
	logic [31:0] mem_q [16];
	logic [3:0] ra_q;
	logic [2:0] wt_q = 3'h0;
	initial begin
		rvalid_o = 1'b0;
		rdata_o = 32'h0;
		foreach (mem_q[i]) mem_q[i] = 32'h0ff055aa;
	end
	always @(posedge mclk_i) begin
		foreach (we_i[k]) if (we_i[k]) mem_q[addr_i[3:0]][8*k+:8] <= wdata_i[8*k+:8];
		rvalid_o <= wt_q == 3'h1;
		// idle data toggles so stale data never passes for an answer
		rdata_o <= wt_q == 3'h1 ? mem_q[ra_q] : ~rdata_o;
		if (rd_i) begin
			ra_q <= addr_i[3:0];
			wt_q <= slow_i ? 3'h5 : 3'h2;
		end else if (wt_q != 3'h0) begin
			wt_q <= wt_q - 3'h1;
		end
	end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`include "gfx_datapath_regs.vh"
module testbench;
	typedef struct {
		logic [7:0] md, rot, sr, sre, msk, cpu;
		logic [31:0] ex;
	} row_t;
	localparam logic [31:0] init_word = 32'h0ff055aa;
	row_t rows [9] = '{
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h81, 32'h81818181},
		'{8'h00, 8'h01, 8'h00, 8'h00, 8'hff, 8'h01, 32'h80808080},
		'{8'h00, 8'h00, 8'h01, 8'h05, 8'hf0, 8'h33, 32'h3f0035fa},
		'{8'h00, 8'h08, 8'h00, 8'h00, 8'hff, 8'h3c, 32'h0c301428},
		'{8'h00, 8'h10, 8'h00, 8'h00, 8'hff, 8'h3c, 32'h3ffc7dbe},
		'{8'h00, 8'h18, 8'h00, 8'h00, 8'hff, 8'h3c, 32'h33cc6996},
		'{8'h01, 8'h18, 8'h00, 8'h00, 8'hff, 8'h3c, 32'h0ff055aa},
		'{8'h02, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h05, 32'h00ff50af},
		'{8'h03, 8'h04, 8'h03, 8'h00, 8'h3c, 8'hf0, 32'h03f05dae}};
	logic [7:0] rbk [6] = '{8'h1f, 8'h03, 8'h7b, 8'h0f, 8'h0f, 8'hff};
	logic [7:0] hit_tbl [4] = '{8'h1e, 8'h06, 8'h08, 8'h10};
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [15:0] io_addr_i = 16'h0000;
	logic io_wr_i = 1'b0;
	logic io_rd_i = 1'b0;
	logic [7:0] io_wdata_i = 8'h00;
	logic [19:0] mem_addr_i = 20'h00000;
	logic mem_wr_i = 1'b0;
	logic mem_rd_i = 1'b0;
	logic [7:0] mem_wdata_i = 8'h00;
	logic seq_chain_i = 1'b0;
	logic shift_load_i = 1'b0;
	logic dot_en_i = 1'b0;
	logic [31:0] shift_data_i = 32'h0;
	logic [1:0] attr_msb_i = 2'h3;
	logic slow = 1'b0;
	wire [7:0] io_rdata_o, mem_rdata_o, pixel_o;
	wire io_rvalid_o, mem_hit_o, mem_rvalid_o, map_rd_o, map_rvalid_i, gfx_mode_o;
	wire [15:0] map_addr_o;
	wire [3:0] map_we_o;
	wire [31:0] map_wdata_o, map_rdata_i;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	gfx_datapath uut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
		.io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.io_rvalid_o(io_rvalid_o), .mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i),
		.mem_rd_i(mem_rd_i), .mem_wdata_i(mem_wdata_i), .mem_hit_o(mem_hit_o),
		.mem_rdata_o(mem_rdata_o), .mem_rvalid_o(mem_rvalid_o), .seq_chain_i(seq_chain_i),
		.map_addr_o(map_addr_o), .map_we_o(map_we_o), .map_rd_o(map_rd_o),
		.map_wdata_o(map_wdata_o), .map_rdata_i(map_rdata_i), .map_rvalid_i(map_rvalid_i),
		.shift_load_i(shift_load_i), .dot_en_i(dot_en_i), .shift_data_i(shift_data_i),
		.attr_msb_i(attr_msb_i), .pixel_o(pixel_o), .gfx_mode_o(gfx_mode_o)
	);
	map_mem_model mem (
		.mclk_i(mclk_i), .addr_i(map_addr_o), .we_i(map_we_o), .rd_i(map_rd_o),
		.wdata_i(map_wdata_o), .slow_i(slow), .rdata_o(map_rdata_i), .rvalid_o(map_rvalid_i)
	);
	always #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
		cmp_count++;
		if (got !== ex) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic io_put(input logic [15:0] a, input logic [7:0] d);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(negedge mclk_i);
		io_wr_i = 1'b0;
		@(negedge mclk_i);
	endtask
	task automatic reg_wr(input logic [3:0] i, input logic [7:0] d);
		io_put(`GFX_PORT_INDEX, {4'h0, i});
		io_put(`GFX_PORT_DATA, d);
	endtask
	task automatic reg_rd(input logic [3:0] i, input logic [7:0] ex);
		io_put(`GFX_PORT_INDEX, {4'h0, i});
		io_addr_i = `GFX_PORT_DATA;
		io_rd_i = 1'b1;
		@(negedge mclk_i);
		io_rd_i = 1'b0;
		for (n = 0; n < 4 && io_rvalid_o !== 1'b1; n++) @(negedge mclk_i);
		chk("io_rvalid", io_rvalid_o, 1'b1);
		chk("reg", io_rdata_o, ex);
		@(negedge mclk_i);
	endtask
	task automatic mem_rd(input logic [19:0] a, input logic [7:0] ex);
		mem_addr_i = a;
		mem_rd_i = 1'b1;
		@(negedge mclk_i);
		mem_rd_i = 1'b0;
		for (n = 0; n < 20 && mem_rvalid_o !== 1'b1; n++) @(negedge mclk_i);
		chk("mem_rvalid", mem_rvalid_o, 1'b1);
		chk("mem_rdata", mem_rdata_o, ex);
		@(negedge mclk_i);
	endtask
	task automatic mem_wr(input logic [19:0] a, input logic [7:0] d, input logic [3:0] we,
			input logic [31:0] ex);
		mem_addr_i = a;
		mem_wdata_i = d;
		mem_wr_i = 1'b1;
		@(negedge mclk_i);
		mem_wr_i = 1'b0;
		for (n = 0; n < 4 && map_we_o === 4'h0; n++) @(negedge mclk_i);
		chk("map_we", map_we_o, we);
		if (we !== 4'h0) chk("map_wdata", map_wdata_o, ex);
		@(negedge mclk_i);
	endtask
	task automatic pix(input logic [7:0] ex);
		shift_load_i = 1'b1;
		@(negedge mclk_i);
		shift_load_i = 1'b0;
		dot_en_i = 1'b1;
		@(negedge mclk_i);
		dot_en_i = 1'b0;
		chk("pixel", pixel_o, ex);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge mclk_i);
		reset_n_i = 1'b1;
		reg_wr(`GFX_IDX_MISC, 8'h05);
		chk("gfx_mode", gfx_mode_o, 1'b1);
		mem_rd(20'ha0010, 8'haa);
		foreach (rows[i]) begin
			reg_wr(`GFX_IDX_MODE, rows[i].md);
			reg_wr(`GFX_IDX_ROTATE, rows[i].rot);
			reg_wr(`GFX_IDX_SET_RESET, rows[i].sr);
			reg_wr(`GFX_IDX_SR_ENABLE, rows[i].sre);
			reg_wr(`GFX_IDX_BIT_MASK, rows[i].msk);
			mem_wr(20'ha0000, rows[i].cpu, 4'hf, rows[i].ex);
		end
		$display("write rows done");
		foreach (rbk[i]) begin
			reg_wr(4'h3 + i[3:0], 8'hff);
			reg_rd(4'h3 + i[3:0], rbk[i]);
		end
		reset_n_i = 1'b0;
		@(negedge mclk_i);
		reset_n_i = 1'b1;
		foreach (rbk[i]) reg_rd(4'h3 + i[3:0], 8'h00);
		$display("readback done");
		reg_wr(`GFX_IDX_MISC, 8'h05);
		for (int p = 0; p < 4; p++) begin
			reg_wr(`GFX_IDX_READ_PLANE, p[7:0]);
			mem_rd(20'ha0011, init_word[8*p+:8]);
		end
		reg_wr(`GFX_IDX_MODE, 8'h08);
		reg_wr(`GFX_IDX_CMP_COLOR, 8'h01);
		reg_wr(`GFX_IDX_CMP_INCLUDE, 8'h03);
		mem_rd(20'ha0011, 8'haa);
		reg_wr(`GFX_IDX_CMP_INCLUDE, 8'h00);
		mem_rd(20'ha0011, 8'hff);
		reg_wr(`GFX_IDX_MODE, 8'h00);
		seq_chain_i = 1'b1;
		slow = 1'b1;
		mem_rd(20'ha0011, 8'h55);
		seq_chain_i = 1'b0;
		$display("reads done");
		reg_wr(`GFX_IDX_MODE, 8'h10);
		mem_wr(20'ha0003, 8'h00, 4'ha, init_word);
		reg_wr(`GFX_IDX_MODE, 8'h00);
		reg_wr(`GFX_IDX_MISC, 8'h07);
		mem_wr(20'ha0004, 8'h00, 4'h5, init_word);
		mem_wr(20'ha0005, 8'h00, 4'ha, init_word);
		chk("map_addr", map_addr_o, 32'h00000004);
		reg_wr(`GFX_IDX_MISC, 8'h0c);
		mem_wr(20'ha0000, 8'h00, 4'h0, 32'h0);
		for (int w = 0; w < 4; w++) begin
			reg_wr(`GFX_IDX_MISC, {4'h0, w[1:0], 2'h0});
			mem_wr_i = 1'b1;
			for (int j = 0; j < 8; j++) begin
				mem_addr_i = 20'h9c000 + 20'h08000 * j;
				#10;
				chk("mem_hit", mem_hit_o, hit_tbl[w][j]);
				@(negedge mclk_i);
			end
			mem_wr_i = 1'b0;
		end
		$display("odd even and window done");
		shift_data_i = 32'h80008000;
		pix(8'hca);
		reg_wr(`GFX_IDX_MODE, 8'h20);
		shift_data_i = 32'h40000000;
		pix(8'hc4);
		reg_wr(`GFX_IDX_MODE, 8'h40);
		shift_data_i = 32'h44332211;
		pix(8'h11);
		$display("shift done");
		final_report();
	end
endmodule
bind gfx_datapath gfx_datapath_asserts u_chk (
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
	.io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rvalid_o(io_rvalid_o),
	.mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i), .mem_hit_o(mem_hit_o),
	.mem_rvalid_o(mem_rvalid_o), .map_we_o(map_we_o), .map_rd_o(map_rd_o),
	.map_rvalid_i(map_rvalid_i), .shift_load_i(shift_load_i), .dot_en_i(dot_en_i),
	.pixel_o(pixel_o)
);
